// File: core/sram_port_ctrl.sv
// Purpose: controller driving an asynchronous 16-bit static memory by its pins
// Assumes: inputs synchronous to core_clk; memory pins registered on core_clk
// Notes: one access at a time; speed grade fixed at build time by SPEED_GRADE

// Function
// - write strobe held high during reads
// - reads drive select and output enable low
// - address set on the same edge that select falls
// - address changes only with select high
// - write ends on first strobe rise
// - select low long enough before write end
// - byte enables low long before write end
// - address valid long before write end
// - retention allowed right after deselect
// - lower enable gates low byte, upper high
module sram_port_ctrl
  #(
    parameter int SPEED_GRADE = 0 // 0 fast, 1 slow
  )
  (
    input wire logic core_clk,
    input wire logic rst,
    input wire sram_port_pkg::user_req_t req,
    output sram_port_pkg::user_rsp_t rsp,
    output sram_port_pkg::mem_pins_t pins,
    input wire logic [sram_port_pkg::DATA_W-1:0] dataIn
  );
  import sram_port_pkg::*;

  // ---------------------------------------------------------------
  // derived cycle counts
  // ---------------------------------------------------------------
  // write pulse must cover select, byte and address setup at once
  localparam int WR_NS_A = (SELECT_TO_WRITE_END_NS[SPEED_GRADE] >
                            BYTE_TO_WRITE_END_NS[SPEED_GRADE]) ?
                           SELECT_TO_WRITE_END_NS[SPEED_GRADE] :
                           BYTE_TO_WRITE_END_NS[SPEED_GRADE];
  localparam int WR_NS = (WR_NS_A > ADDRESS_TO_WRITE_END_NS[SPEED_GRADE]) ?
                         WR_NS_A : ADDRESS_TO_WRITE_END_NS[SPEED_GRADE];
  localparam int WR_CYC = cyclesUp(WR_NS);
  // read sample waits for the slower of select and oe access
  localparam int RD_NS = (SELECT_ACCESS_TIME_NS[SPEED_GRADE] >
                          OUTPUT_ENABLE_ACCESS_NS[SPEED_GRADE]) ?
                         SELECT_ACCESS_TIME_NS[SPEED_GRADE] :
                         OUTPUT_ENABLE_ACCESS_NS[SPEED_GRADE];
  localparam int RD_CYC = cyclesUp(RD_NS);
  // turnaround after a read: memory must have floated the bus
  localparam int FL_NS = (DESELECT_TO_FLOAT_NS > OUTPUT_DISABLE_TO_FLOAT_NS) ?
                         DESELECT_TO_FLOAT_NS : OUTPUT_DISABLE_TO_FLOAT_NS;
  localparam int FL_CYC = cyclesUp(FL_NS);
  // drive data only after memory released the bus on strobe fall
  localparam int WZ_CYC = cyclesUp(WRITE_TO_FLOAT_NS);
  localparam int HOLD_CYC = cyclesUp(WRITE_END_TO_DRIVE_NS);
  localparam int RET_CYC = cyclesUp(DESELECT_TO_RETENTION_NS);

  // elaboration checks
  if (SPEED_GRADE != 0 && SPEED_GRADE != 1)
    $error("SPEED_GRADE must be 0 or 1");
  if (WR_CYC + WZ_CYC >= (1 << CNT_W) || RD_CYC >= (1 << CNT_W))
    $error("phase counter too narrow");

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic [CNT_W-1:0] cnt;
    mem_pins_t pins;
    user_rsp_t rsp;
  } state_t;

  state_t s_r; // registered state
  state_t s_nxt; // next state

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rsp.rdValid = 1'b0; // pulse
    unique case (s_r.phase)
      ST_IDLE:
      begin
        // address, lanes and select all set on the same edge
        if (req.valid)
        begin
          s_nxt.rsp.ready = 1'b0;
          s_nxt.rsp.idle = 1'b0;
          s_nxt.pins.addr = req.addr;
          s_nxt.pins.chipSel_n = 1'b0;
          s_nxt.pins.lower_byte_en_n = ~req.byteEn[0];
          s_nxt.pins.upper_byte_en_n = ~req.byteEn[1];
          if (req.write)
          begin
            // strobe low with select; data held back until bus floats
            s_nxt.pins.writeStrobe_n = 1'b0;
            s_nxt.pins.outEnable_n = 1'b1;
            s_nxt.pins.dataOut = req.wdata;
            s_nxt.cnt = CNT_W'(WR_CYC + WZ_CYC - 1);
            s_nxt.phase = ST_WR_PULSE;
          end
          else
          begin
            s_nxt.pins.writeStrobe_n = 1'b1;
            s_nxt.pins.outEnable_n = 1'b0;
            s_nxt.cnt = CNT_W'(RD_CYC - 1);
            s_nxt.phase = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT:
      begin
        // count down the access time, then sample
        if (s_r.cnt == '0)
        begin
          s_nxt.rsp.rdata = dataIn;
          s_nxt.rsp.rdValid = 1'b1;
          s_nxt.pins.chipSel_n = 1'b1;
          s_nxt.pins.outEnable_n = 1'b1;
          s_nxt.cnt = CNT_W'(FL_CYC - 1);
          s_nxt.phase = ST_RD_DONE;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      ST_RD_DONE:
      begin
        // wait out the float time before anyone drives the bus
        if (s_r.cnt == '0)
          s_nxt.phase = ST_FLOAT;
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      ST_WR_PULSE:
      begin
        // drive data only once the memory has let go: WZ_CYC after strobe fall,
        // which leaves the full WR_CYC of data setup before the write ends
        if (s_r.cnt == CNT_W'(WR_CYC))
          s_nxt.pins.dataOe = 1'b1;
        if (s_r.cnt == '0)
        begin
          // strobe and select rise together; write ends here
          s_nxt.pins.writeStrobe_n = 1'b1;
          s_nxt.pins.chipSel_n = 1'b1;
          s_nxt.cnt = CNT_W'(HOLD_CYC - 1);
          s_nxt.phase = ST_WR_END;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      ST_WR_END:
      begin
        // data held past the edge, memory stays quiet meanwhile
        if (s_r.cnt == '0)
        begin
          s_nxt.pins.dataOe = 1'b0;
          s_nxt.phase = ST_FLOAT;
        end
        else
          s_nxt.cnt = s_r.cnt - 1'b1;
      end
      ST_FLOAT:
      begin
        // deselected: idle marks retention entry allowed at once
        s_nxt.pins.lower_byte_en_n = 1'b1;
        s_nxt.pins.upper_byte_en_n = 1'b1;
        s_nxt.cnt = CNT_W'(RET_CYC - 1);
        s_nxt.rsp.ready = 1'b1;
        s_nxt.rsp.idle = 1'b1;
        s_nxt.phase = ST_IDLE;
      end
      default:
        s_nxt.phase = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.phase <= ST_IDLE;
      s_r.pins.chipSel_n <= 1'b1; // deselected out of reset
      s_r.pins.writeStrobe_n <= 1'b1;
      s_r.pins.outEnable_n <= 1'b1;
      s_r.pins.upper_byte_en_n <= 1'b1;
      s_r.pins.lower_byte_en_n <= 1'b1;
      s_r.rsp.ready <= 1'b1;
      s_r.rsp.idle <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign pins = s_r.pins;
  assign rsp = s_r.rsp;

endmodule // sram_port_ctrl

// File: core/sram_port_pkg.sv
// Purpose: shared constants and types for the static memory port controller
// Assumes: core clock of 50 MHz (20 ns period)
// Notes: all delays are counted in whole core clock cycles, rounded up
package sram_port_pkg;

  // ---------------------------------------------------------------
  // clock and widths
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20; // core clock period
  localparam int ADDR_W = 18; // word address width
  localparam int DATA_W = 16; // data bus width
  localparam int BYTE_W = 8; // one byte lane

  // ---------------------------------------------------------------
  // timing figures in ns; pairs per speed grade (0 = fast, 1 = slow), single values shared by both
  // ---------------------------------------------------------------
  localparam int SELECT_TO_WRITE_END_NS [2] = '{40, 60};
  localparam int BYTE_TO_WRITE_END_NS [2] = '{35, 55};
  localparam int ADDRESS_TO_WRITE_END_NS [2] = '{40, 60};
  localparam int SELECT_ACCESS_TIME_NS [2] = '{55, 70};
  localparam int OUTPUT_ENABLE_ACCESS_NS [2] = '{25, 35};
  localparam int DESELECT_TO_FLOAT_NS = 20; // bus release after deselect
  localparam int OUTPUT_DISABLE_TO_FLOAT_NS = 20; // bus release after oe high
  localparam int WRITE_TO_FLOAT_NS = 20; // memory floats after strobe low
  localparam int WRITE_END_TO_DRIVE_NS = 5; // memory quiet after write end
  localparam int DESELECT_TO_RETENTION_NS = 0; // retention may follow deselect

  // round a least time up to whole cycles, never below one
  function automatic int cyclesUp(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 4; // width of the phase counter

  // ---------------------------------------------------------------
  // state and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD_WAIT = 3'h1,
    ST_RD_DONE = 3'h3,
    ST_WR_PULSE = 3'h4,
    ST_WR_END = 3'h5,
    ST_FLOAT = 3'h2
  } phase_t;

  // pins toward the memory, active-low strobes plus the active-high dataOe
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chipSel_n;
    logic writeStrobe_n;
    logic outEnable_n;
    logic upper_byte_en_n;
    logic lower_byte_en_n;
    logic [DATA_W-1:0] dataOut;
    logic dataOe;
  } mem_pins_t;

  // user request
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] byteEn; // bit1 upper lane, bit0 lower lane
  } user_req_t;

  // user answer
  typedef struct packed {
    logic ready;
    logic rdValid;
    logic [DATA_W-1:0] rdata;
    logic idle; // deselected, safe to lower supply
  } user_rsp_t;

endpackage : sram_port_pkg

// File: tb/async_sram_word_port_tb.sv
// Purpose: bench for the static memory port controller
// Assumes: fast grade, behavioural memory on the far side
// Notes: inputs move on the falling edge
module async_sram_word_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sram_port_pkg::*;
  logic core_clk, rst, clash;
  user_req_t req;
  user_rsp_t rsp;
  mem_pins_t pins;
  logic [15:0] dataIn;
  int bad_count, tests_run, cyc;
  always #10 core_clk = ~core_clk;
  sram_port_ctrl #(.SPEED_GRADE(0)) u_dut (.core_clk(core_clk), .rst(rst), .req(req),
    .rsp(rsp), .pins(pins), .dataIn(dataIn));
  sram_model #(.ACC_NS(55)) u_mem (.core_clk(core_clk), .pins(pins), .dataIn(dataIn),
    .clash(clash));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access; lat counts cycles from take to read data
  task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d,
    input logic [1:0] be, output logic [15:0] lat);
    lat = 16'h0000;
    @(negedge core_clk);
    while (rsp.ready !== 1'h1)
      @(negedge core_clk);
    req = '{1'h1, w, a, d, be};
    @(negedge core_clk);
    req.valid = 1'h0;
    lat = 16'h0001; // first look lies one edge past the take edge
    while (!w && rsp.rdValid !== 1'h1 && lat < 16'h0014)
    begin
      @(negedge core_clk);
      lat++;
    end
  endtask
  task automatic t_word;
    logic [15:0] l;
    access(1'h1, 18'h00000, 16'hA55A, 2'h3, l);
    access(1'h1, 18'h3FFFF, 16'h0FF0, 2'h3, l);
    access(1'h0, 18'h00000, 16'h0000, 2'h3, l);
    check(rsp.rdata, 16'hA55A);
    check(l, 16'h0004);
    access(1'h0, 18'h3FFFF, 16'h0000, 2'h3, l);
    check(rsp.rdata, 16'h0FF0);
    $display("word test done");
  endtask
  task automatic t_lanes;
    logic [15:0] l;
    access(1'h1, 18'h00100, 16'h1234, 2'h3, l);
    access(1'h1, 18'h00100, 16'hABCD, 2'h1, l);
    access(1'h1, 18'h00100, 16'hEF00, 2'h0, l);
    access(1'h0, 18'h00100, 16'h0000, 2'h3, l);
    check(rsp.rdata, 16'h12CD);
    access(1'h0, 18'h00100, 16'h0000, 2'h2, l);
    check({8'h00, rsp.rdata[15:8]}, 16'h0012);
    $display("lane test done");
  endtask
  task automatic t_idle;
    repeat (2) @(negedge core_clk);
    check({11'h000, rsp.idle, pins.chipSel_n, pins.upper_byte_en_n,
      pins.lower_byte_en_n, clash}, 16'h001E);
    $display("idle test done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      bad_count++;
      finish_test;
    end
  end
  initial
  begin
    core_clk = 1'h0;
    rst = 1'h1;
    req = '0;
    repeat (6) @(negedge core_clk);
    rst = 1'h0;
    t_word;
    t_lanes;
    t_idle;
    finish_test;
  end
endmodule // async_sram_word_port_tb

// File: tb/sram_model.sv
// Purpose: behavioural word memory on the far side of the port
// Assumes: controller pins change on core_clk
// Notes: no pull-ups, so an undriven lane shows a pattern that flips
module sram_model
  #(
    parameter int ACC_NS = 55 // access delay, prompt or slow
  )
  (
    input wire logic core_clk,
    input wire sram_port_pkg::mem_pins_t pins,
    output logic [15:0] dataIn,
    output logic clash
  );
  import sram_port_pkg::*;
  logic [15:0] mem [int]; // stored words
  logic [15:0] fl = 16'h5AA5; // float pattern
  logic [15:0] rw, ww, wd; // read word, write scratch, write data
  logic [1:0] wl; // lanes of the write
  int wa; // address of the write
  wire lanes = !(pins.upper_byte_en_n && pins.lower_byte_en_n);
  wire selLo = !pins.chipSel_n;
  wire rdOn = selLo && !pins.outEnable_n && pins.writeStrobe_n && lanes;
  wire wrOn = selLo && !pins.writeStrobe_n && lanes;
  wire late;
  assign #(ACC_NS) late = rdOn;
  // pattern flips each cycle; sticky flag if both sides drive
  always @(posedge core_clk)
  begin
    fl <= ~fl;
    if (pins.dataOe && rdOn)
      clash <= 1'h1;
    else if (clash !== 1'h1)
      clash <= 1'h0; // clean until the first clash
  end
  // bus level, lane by lane; old data only while still selected
  always @*
  begin
    rw = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : fl;
    dataIn = fl;
    if (rdOn && late && !pins.lower_byte_en_n)
      dataIn[7:0] = rw[7:0];
    if (rdOn && late && !pins.upper_byte_en_n)
      dataIn[15:8] = rw[15:8];
    if (pins.dataOe)
      dataIn = pins.dataOut;
  end
  // track what the write holds while it is open
  always @*
    if (wrOn)
    begin
      wa = int'(pins.addr);
      wl = ~{pins.upper_byte_en_n, pins.lower_byte_en_n};
      wd = dataIn;
    end
  // first rise of select or strobe lands the write
  always @(negedge wrOn)
  begin
    ww = mem.exists(wa) ? mem[wa] : 16'h0000;
    if (wl[0])
      ww[7:0] = wd[7:0];
    if (wl[1])
      ww[15:8] = wd[15:8];
    mem[wa] = ww;
  end
endmodule // sram_model

// File: tb/sram_port_ctrl_properties.sv
// Purpose: timing checks on the memory port pins
// Assumes: one clock, sync reset
// Notes: cycle counts follow the grade handed in
module sram_port_ctrl_properties
  #(
    parameter int SPEED_GRADE = 0 // 0 fast, 1 slow
  )
  (
    input wire logic core_clk,
    input wire logic rst,
    input wire sram_port_pkg::user_req_t req,
    input wire sram_port_pkg::user_rsp_t rsp,
    input wire sram_port_pkg::mem_pins_t pins,
    input wire logic [sram_port_pkg::DATA_W-1:0] dataIn
  );
  import sram_port_pkg::*;
  localparam int RD_C = SPEED_GRADE ? 5 : 4; // take to read data
  localparam int WE_C = SPEED_GRADE ? 5 : 4; // take to write end
  localparam int WP_C = SPEED_GRADE ? 3 : 2; // 60 or 40 ns in 20 ns cycles
  logic [3:0] lowCnt; // cycles that select and strobe have both been low
  always_ff @(posedge core_clk)
    if (rst || pins.writeStrobe_n || pins.chipSel_n)
      lowCnt <= 4'h0;
    else if (lowCnt != 4'hF)
      lowCnt <= lowCnt + 4'h1;
  wire takeRd = req.valid && rsp.ready && !req.write;
  wire takeWr = req.valid && rsp.ready && req.write;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_read_pins: assert property (
    takeRd |=> !pins.chipSel_n && !pins.outEnable_n) else $error("read strobes");
  a_strobe_read: assert property (
    !pins.outEnable_n |-> pins.writeStrobe_n) else $error("strobe in read");
  a_addr_stable: assert property (
    !pins.chipSel_n && !$past(pins.chipSel_n) |-> $stable(pins.addr)) else $error("addr moved");
  a_read_latency: assert property (
    takeRd |-> ##RD_C rsp.rdValid) else $error("read late");
  a_write_end: assert property (
    takeWr |-> ##WE_C $rose(pins.writeStrobe_n) && $rose(pins.chipSel_n)) else $error("write end");
  a_write_hold: assert property (
    $rose(pins.writeStrobe_n) |-> lowCnt >= WP_C) else $error("write short");
  a_lane_hold: assert property (
    !pins.writeStrobe_n && !$fell(pins.writeStrobe_n) |-> $stable(pins.addr)
    && $stable({pins.upper_byte_en_n, pins.lower_byte_en_n})) else $error("lanes moved");
  a_float_gap: assert property (
    $fell(pins.writeStrobe_n) |-> !pins.dataOe) else $error("drive early");
  a_drive_over: assert property (
    $rose(pins.writeStrobe_n) |-> pins.dataOe ##1 !pins.dataOe) else $error("drive off");
  a_idle_desel: assert property (
    rsp.ready |-> pins.chipSel_n && pins.upper_byte_en_n && pins.lower_byte_en_n)
    else $error("idle pins");
  a_lane_map: assert property (
    takeWr |=> {pins.upper_byte_en_n, pins.lower_byte_en_n} == ~$past(req.byteEn))
    else $error("lane map");
  c_read: cover property (takeRd);
  c_write: cover property (takeWr);
  c_lane: cover property (takeWr && req.byteEn == 2'h1);
endmodule // sram_port_ctrl_properties
bind sram_port_ctrl sram_port_ctrl_properties #(.SPEED_GRADE(SPEED_GRADE)) u_props (
  .core_clk(core_clk), .rst(rst), .req(req), .rsp(rsp), .pins(pins), .dataIn(dataIn));
